// ==== hw/ctx_cfg.svh ====
`ifndef CTX_CFG_SVH
`define CTX_CFG_SVH

// ----------------------------------------
// vector locations
// ----------------------------------------
`define INT_VEC_BASE 16'h0000
`define XOP_VEC_BASE 16'h0040
`define LOAD_VEC_ADDR 16'hFFFC
`define VEC_SHIFT 2
`define VEC_PC_OFS 16'h0002

// ----------------------------------------
// save slots in the new workspace
// ----------------------------------------
`define R13_OFS 16'h001A
`define R14_OFS 16'h001C
`define R15_OFS 16'h001E

// ----------------------------------------
// byte lanes and reset values
// ----------------------------------------
`define BE_WORD 2'b11
`define BE_EVEN 2'b10
`define BE_ODD 2'b01
`define WORD_BYTES 16'h0002
`define RST_WP 16'h0000
`define RST_PC 16'h0000

`endif

// ==== hw/ctx_pkg.sv ====
package ctx_pkg;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_RD_WP = 4'b0001,
        ST_RD_PC = 4'b0010,
        ST_WR13 = 4'b0011,
        ST_WR14 = 4'b0100,
        ST_WR15 = 4'b0101,
        ST_LOAD = 4'b0110,
        ST_FLAG = 4'b0111,
        ST_HWX = 4'b1000
    } state_t;

    typedef enum logic [1:0] {
        CAUSE_LOAD = 2'b00,
        CAUSE_INT = 2'b01,
        CAUSE_XOP = 2'b10,
        CAUSE_VBR = 2'b11
    } cause_t;

endpackage : ctx_pkg

// ==== hw/word_port_if.sv ====
`timescale 1ns/1ps

interface word_port_if;
    logic req;
    logic we;
    logic byte_mode;
    logic sign_ext;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic done;

    modport master (
        output req, we, byte_mode, sign_ext, addr, wdata,
        input rdata, done
    );
    modport slave (
        input req, we, byte_mode, sign_ext, addr, wdata,
        output rdata, done
    );
endinterface : word_port_if

// ==== hw/mem_access.sv ====
`timescale 1ns/1ps
`include "ctx_cfg.svh"

module mem_access (
    input wire logic clk,
    input wire logic rst,
    word_port_if.slave port,
    output logic mem_req,
    output logic mem_we,
    output logic [15:0] mem_addr,
    output logic [1:0] mem_be,
    output logic [15:0] mem_wdata,
    input wire logic [15:0] mem_rdata,
    input wire logic mem_ack
);
    logic ack_seen_r;
    logic done_r;
    logic [15:0] rdata_r;
    logic [7:0] rbyte;

    // ----------------------------------------
    // address and lanes
    // ----------------------------------------
    // low address bit never reaches memory: words are always even
    assign mem_addr = {port.addr[15:1], 1'b0};
    // bit 0 is the msb, so the even byte sits in the upper lane
    assign mem_be = !port.byte_mode ? `BE_WORD :
                    (port.addr[0] ? `BE_ODD : `BE_EVEN);
    assign mem_wdata = port.byte_mode ?
                       {port.wdata[7:0], port.wdata[7:0]} : port.wdata;
    assign mem_we = port.we;
    // drop request once acked so memory sees one access only
    assign mem_req = port.req && !ack_seen_r;
    assign rbyte = port.addr[0] ? mem_rdata[7:0] : mem_rdata[15:8];

    // ----------------------------------------
    // completion
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            ack_seen_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            ack_seen_r <= (mem_req && mem_ack) ||
                          (ack_seen_r && !done_r);
            done_r <= mem_req && mem_ack;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_r <= 16'h0000;
        end else if (mem_req && mem_ack) begin
            if (port.byte_mode) begin
                rdata_r <= {{8{port.sign_ext && rbyte[7]}}, rbyte};
            end else begin
                rdata_r <= mem_rdata;
            end
        end
    end

    assign port.rdata = rdata_r;
    assign port.done = done_r;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_word_even_addr: assert property (mem_req |-> !mem_addr[0])
        else $error("odd word address on memory bus");
    a_byte_lane_pick: assert property (mem_req && port.byte_mode |->
        mem_be == (port.addr[0] ? `BE_ODD : `BE_EVEN))
        else $error("byte lane mismatch");
    a_byte_sign_ext: assert property (mem_req && mem_ack &&
        port.byte_mode && port.sign_ext |=>
        rdata_r[15:8] == {8{rdata_r[7]}})
        else $error("byte read not sign extended");
    a_done_one_pulse: assert property (done_r |=> !done_r)
        else $error("done held more than one cycle");

endmodule : mem_access

// ==== hw/ctx_switch.sv ====
// Operation
// - memory addressed in eight bit bytes
// - msb of a byte is bit zero
// - word is even byte then odd byte
// - odd word address uses preceding even word
// - instructions even aligned, one to three words
// - signed values are two's complement
// - switch loads workspace pointer from first word
// - switch loads program counter from second word
// - interrupt level vector at level times four
// - extended operation vector at four n plus 40h
// - load restart uses vector at FFFCh
// - vector branch uses program supplied vector address
// - hardware extended operation waits, no switch
// - extended flag set after wp and pc load
`timescale 1ns/1ps
`include "ctx_cfg.svh"

module ctx_switch (
    input wire logic clk,
    input wire logic rst,
    input wire logic int_req,
    input wire logic [3:0] int_level,
    input wire logic xop_req,
    input wire logic [3:0] xop_num,
    input wire logic load_restart_instr,
    input wire logic load_pin,
    input wire logic vector_branch_instr,
    input wire logic [15:0] vbranch_addr,
    input wire logic hw_xop_present_pin,
    input wire logic hw_xop_done_pin,
    input wire logic [15:0] cur_status,
    input wire logic fetch_adv,
    input wire logic [1:0] instr_len,
    input wire logic cpu_req,
    input wire logic cpu_we,
    input wire logic cpu_byte,
    input wire logic cpu_signed,
    input wire logic [15:0] cpu_addr,
    input wire logic [15:0] cpu_wdata,
    output logic [15:0] cpu_rdata,
    output logic cpu_done,
    output logic [15:0] wp,
    output logic [15:0] pc,
    output logic xop_flag,
    output logic busy,
    output logic switch_done,
    output logic mem_req,
    output logic mem_we,
    output logic [15:0] mem_addr,
    output logic [1:0] mem_be,
    output logic [15:0] mem_wdata,
    input wire logic [15:0] mem_rdata,
    input wire logic mem_ack
);
    ctx_pkg::state_t state_r;
    ctx_pkg::cause_t cause_r;
    logic [15:0] vec_r, new_wp_r, new_pc_r, wp_r, pc_r, st_save_r;
    logic xop_flag_r, switch_done_r;
    logic [2:0] load_sync_r;
    logic [1:0] hwp_sync_r, hwd_sync_r;
    logic load_edge, idle, start_any;

    word_port_if bus ();

    mem_access u_mem (
        .clk(clk), .rst(rst), .port(bus.slave),
        .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
        .mem_be(mem_be), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
        .mem_ack(mem_ack)
    );

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            load_sync_r <= 3'b000;
            hwp_sync_r <= 2'b00;
            hwd_sync_r <= 2'b00;
        end else begin
            load_sync_r <= {load_sync_r[1:0], load_pin};
            hwp_sync_r <= {hwp_sync_r[0], hw_xop_present_pin};
            hwd_sync_r <= {hwd_sync_r[0], hw_xop_done_pin};
        end
    end
    // edge taken from second and third stage only
    assign load_edge = load_sync_r[1] && !load_sync_r[2];

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    assign idle = state_r == ctx_pkg::ST_IDLE;
    // cpu access in flight wins; switch waits for a quiet port
    assign start_any = idle && !cpu_req && (load_edge ||
        load_restart_instr || int_req || xop_req || vector_branch_instr);

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= ctx_pkg::ST_IDLE;
            cause_r <= ctx_pkg::CAUSE_LOAD;
            vec_r <= `LOAD_VEC_ADDR;
            st_save_r <= 16'h0000;
        end else begin
            unique case (state_r)
                ctx_pkg::ST_IDLE: begin
                    st_save_r <= cur_status;
                    if (start_any) begin
                        state_r <= ctx_pkg::ST_RD_WP;
                    end
                    if (load_edge || load_restart_instr) begin
                        cause_r <= ctx_pkg::CAUSE_LOAD;
                        vec_r <= `LOAD_VEC_ADDR;
                    end else if (int_req) begin
                        cause_r <= ctx_pkg::CAUSE_INT;
                        vec_r <= `INT_VEC_BASE +
                            (16'(int_level) << `VEC_SHIFT);
                    end else if (xop_req && hwp_sync_r[1]) begin
                        cause_r <= ctx_pkg::CAUSE_XOP;
                        if (start_any) state_r <= ctx_pkg::ST_HWX;
                    end else if (xop_req) begin
                        cause_r <= ctx_pkg::CAUSE_XOP;
                        vec_r <= `XOP_VEC_BASE +
                            (16'(xop_num) << `VEC_SHIFT);
                    end else if (vector_branch_instr) begin
                        cause_r <= ctx_pkg::CAUSE_VBR;
                        vec_r <= {vbranch_addr[15:1], 1'b0};
                    end
                end
                ctx_pkg::ST_RD_WP: if (bus.done) state_r <= ctx_pkg::ST_RD_PC;
                ctx_pkg::ST_RD_PC: if (bus.done) state_r <= ctx_pkg::ST_WR13;
                ctx_pkg::ST_WR13: if (bus.done) state_r <= ctx_pkg::ST_WR14;
                ctx_pkg::ST_WR14: if (bus.done) state_r <= ctx_pkg::ST_WR15;
                ctx_pkg::ST_WR15: if (bus.done) state_r <= ctx_pkg::ST_LOAD;
                ctx_pkg::ST_LOAD:
                    state_r <= (cause_r == ctx_pkg::CAUSE_XOP) ?
                        ctx_pkg::ST_FLAG : ctx_pkg::ST_IDLE;
                ctx_pkg::ST_FLAG: state_r <= ctx_pkg::ST_IDLE;
                ctx_pkg::ST_HWX:
                    if (hwd_sync_r[1]) state_r <= ctx_pkg::ST_IDLE;
                default: state_r <= ctx_pkg::ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // vector words
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            new_wp_r <= `RST_WP;
            new_pc_r <= `RST_PC;
        end else if (bus.done && state_r == ctx_pkg::ST_RD_WP) begin
            new_wp_r <= {bus.rdata[15:1], 1'b0};
        end else if (bus.done && state_r == ctx_pkg::ST_RD_PC) begin
            new_pc_r <= {bus.rdata[15:1], 1'b0};
        end
    end

    // ----------------------------------------
    // workspace pointer and program counter
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            wp_r <= `RST_WP;
            pc_r <= `RST_PC;
        end else if (state_r == ctx_pkg::ST_LOAD) begin
            wp_r <= new_wp_r;
            pc_r <= new_pc_r;
        end else if (idle && fetch_adv && instr_len != 2'b00) begin
            pc_r <= pc_r + (16'(instr_len) << 1);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            xop_flag_r <= 1'b0;
        end else if (state_r == ctx_pkg::ST_FLAG) begin
            xop_flag_r <= 1'b1;
        end else if (state_r == ctx_pkg::ST_LOAD) begin
            xop_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            switch_done_r <= 1'b0;
        end else begin
            switch_done_r <= (state_r == ctx_pkg::ST_LOAD &&
                cause_r != ctx_pkg::CAUSE_XOP) ||
                state_r == ctx_pkg::ST_FLAG ||
                (state_r == ctx_pkg::ST_HWX && hwd_sync_r[1]);
        end
    end

    // ----------------------------------------
    // word port drive
    // ----------------------------------------
    always_comb begin
        bus.req = 1'b0;
        bus.we = 1'b0;
        bus.byte_mode = 1'b0;
        bus.sign_ext = 1'b0;
        bus.addr = vec_r;
        bus.wdata = wp_r;
        unique case (state_r)
            ctx_pkg::ST_IDLE: begin
                bus.req = cpu_req;
                bus.we = cpu_we;
                bus.byte_mode = cpu_byte;
                bus.sign_ext = cpu_signed;
                bus.addr = cpu_addr;
                bus.wdata = cpu_wdata;
            end
            ctx_pkg::ST_RD_WP: bus.req = 1'b1;
            ctx_pkg::ST_RD_PC: begin
                bus.req = 1'b1;
                bus.addr = vec_r + `VEC_PC_OFS;
            end
            ctx_pkg::ST_WR13: begin
                bus.req = 1'b1;
                bus.we = 1'b1;
                bus.addr = new_wp_r + `R13_OFS;
            end
            ctx_pkg::ST_WR14: begin
                bus.req = 1'b1;
                bus.we = 1'b1;
                bus.addr = new_wp_r + `R14_OFS;
                bus.wdata = pc_r;
            end
            ctx_pkg::ST_WR15: begin
                bus.req = 1'b1;
                bus.we = 1'b1;
                bus.addr = new_wp_r + `R15_OFS;
                bus.wdata = st_save_r;
            end
            default: bus.req = 1'b0;
        endcase
    end

    assign cpu_rdata = bus.rdata;
    assign cpu_done = bus.done && idle;
    assign wp = wp_r;
    assign pc = pc_r;
    assign xop_flag = xop_flag_r;
    assign busy = !idle;
    assign switch_done = switch_done_r;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_int_vec_addr: assert property (start_any && int_req &&
        !load_edge && !load_restart_instr |=> vec_r == {10'h000,
        $past(int_level), 2'b00}) else $error("wrong interrupt vector");
    a_xop_vec_addr: assert property (start_any && xop_req &&
        !load_edge && !load_restart_instr && !int_req && !hwp_sync_r[1] |=>
        vec_r == {10'h001, $past(xop_num), 2'b00})
        else $error("wrong extended operation vector");
    a_load_vec_addr: assert property (start_any &&
        (load_edge || load_restart_instr) |=> vec_r == `LOAD_VEC_ADDR)
        else $error("wrong load vector");
    a_vbr_vec_addr: assert property (start_any &&
        vector_branch_instr && !load_edge && !load_restart_instr &&
        !int_req && !xop_req |=> vec_r == {$past(vbranch_addr[15:1]),
        1'b0}) else $error("wrong branch vector");
    a_wp_pc_load: assert property (state_r == ctx_pkg::ST_LOAD |=>
        wp_r == $past(new_wp_r) && pc_r == $past(new_pc_r))
        else $error("wp or pc not loaded");
    a_pc_from_vec: assert property (bus.done &&
        state_r == ctx_pkg::ST_RD_PC |=> new_pc_r ==
        {$past(bus.rdata[15:1]), 1'b0}) else $error("pc word not captured");
    a_xop_flag_after: assert property (
        state_r == ctx_pkg::ST_LOAD && cause_r == ctx_pkg::CAUSE_XOP |=>
        !xop_flag_r ##1 xop_flag_r) else $error("extended flag timing");
    a_hw_xop_hold: assert property (state_r == ctx_pkg::ST_HWX |->
        !mem_req ##1 ($stable(wp_r) && $stable(pc_r)))
        else $error("hardware op disturbed context");
    a_save_regs: assert property (state_r == ctx_pkg::ST_WR13 |->
        mem_we && mem_be == `BE_WORD && mem_addr == new_wp_r + `R13_OFS &&
        mem_wdata == wp_r) else $error("old wp not saved");
    a_fetch_step: assert property (idle && fetch_adv &&
        instr_len != 2'b00 |=> pc_r == $past(pc_r) + {13'h0000,
        $past(instr_len), 1'b0}) else $error("bad fetch advance");

    c_int_switch: cover property (state_r == ctx_pkg::ST_LOAD &&
        cause_r == ctx_pkg::CAUSE_INT);
    c_xop_switch: cover property (state_r == ctx_pkg::ST_FLAG);
    c_hw_xop: cover property (state_r == ctx_pkg::ST_HWX && hwd_sync_r[1]);
    c_vbr_switch: cover property (state_r == ctx_pkg::ST_LOAD &&
        cause_r == ctx_pkg::CAUSE_VBR);

endmodule : ctx_switch

// ==== bench/mem_model.sv ====
`timescale 1ns/1ps

// ----------------------------------------
// system memory holding vectors and workspaces
// ----------------------------------------
module mem_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] wait_cycles,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [15:0] mem_addr,
    input wire logic [1:0] mem_be,
    input wire logic [15:0] mem_wdata,
    output logic [15:0] mem_rdata,
    output logic mem_ack
);
    logic [15:0] store_r [0:32767];
    logic [15:0] rd_r;
    logic [3:0] cnt_r;
    logic ack_r;

    initial begin
        for (int i = 0; i < 32768; i++)
            store_r[i] = 16'h0000;
    end

    // two consecutive words make one vector
    task automatic poke(input logic [15:0] a, input logic [15:0] d);
        store_r[a[15:1]] = d;
    endtask : poke

    function automatic logic [15:0] peek(input logic [15:0] a);
        return store_r[a[15:1]];
    endfunction : peek

    // released data lines show the inverse, so a stale read cannot match
    assign mem_rdata = ack_r ? rd_r : ~rd_r;
    assign mem_ack = ack_r;

    always @(posedge clk) begin
        if (rst) begin
            ack_r <= 1'h0;
            cnt_r <= 4'h0;
        end else if (mem_req && !ack_r && cnt_r < wait_cycles) begin
            cnt_r <= cnt_r + 4'h1;
        end else if (mem_req && !ack_r) begin
            ack_r <= 1'h1;
            cnt_r <= 4'h0;
            rd_r <= store_r[mem_addr[15:1]];
            if (mem_we && mem_be[1])
                store_r[mem_addr[15:1]][15:8] <= mem_wdata[15:8];
            if (mem_we && mem_be[0])
                store_r[mem_addr[15:1]][7:0] <= mem_wdata[7:0];
        end else begin
            ack_r <= 1'h0;
        end
    end
endmodule : mem_model

// ==== bench/tb.sv ====
`timescale 1ns/1ps
`define CHECK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
    miscompares++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end

module tb;
    // ----------------------------------------
    // stimulus and observed signals
    // ----------------------------------------
    logic clk = 1'h0, rst = 1'h1;
    logic int_req = 1'h0, xop_req = 1'h0, load_restart_instr = 1'h0;
    logic load_pin = 1'h0, vector_branch_instr = 1'h0, fetch_adv = 1'h0;
    logic hw_xop_present_pin = 1'h0, hw_xop_done_pin = 1'h0;
    logic cpu_req = 1'h0, cpu_we = 1'h0, cpu_byte = 1'h0, cpu_signed = 1'h0;
    logic [3:0] int_level = 4'h0, xop_num = 4'h0, mem_wait = 4'h0;
    logic [1:0] instr_len = 2'h0;
    logic [15:0] vbranch_addr = 16'h0000, cur_status = 16'h0000;
    logic [15:0] cpu_addr = 16'h0000, cpu_wdata = 16'h0000;
    logic [15:0] cpu_rdata, wp, pc, mem_addr, mem_wdata, mem_rdata;
    logic cpu_done, xop_flag, busy, switch_done, mem_req, mem_we, mem_ack;
    logic [1:0] mem_be;
    logic [15:0] cur_wp = 16'h0000, cur_pc = 16'h0000, rd;
    int miscompares = 0, checks_done = 0, mem_hits = 0;

    always #25 clk = ~clk;
    always @(posedge clk)
        if (mem_req === 1'h1)
            mem_hits++;

    ctx_switch u_dut (.clk, .rst, .int_req, .int_level, .xop_req, .xop_num,
        .load_restart_instr, .load_pin, .vector_branch_instr, .vbranch_addr,
        .hw_xop_present_pin, .hw_xop_done_pin, .cur_status, .fetch_adv,
        .instr_len, .cpu_req, .cpu_we, .cpu_byte, .cpu_signed, .cpu_addr,
        .cpu_wdata, .cpu_rdata, .cpu_done, .wp, .pc, .xop_flag, .busy,
        .switch_done, .mem_req, .mem_we, .mem_addr, .mem_be, .mem_wdata,
        .mem_rdata, .mem_ack);
    mem_model u_mem (.clk, .rst, .wait_cycles(mem_wait), .mem_req, .mem_we,
        .mem_addr, .mem_be, .mem_wdata, .mem_rdata, .mem_ack);

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic results();
        if (miscompares == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : results

    // request dropped on the edge that sees done, so it is not taken twice
    task automatic cpu(input logic w, b, s, input logic [15:0] a, d);
        int n;
        n = 0;
        @(posedge clk);
        {cpu_req, cpu_we, cpu_byte, cpu_signed} <= {1'h1, w, b, s};
        cpu_addr <= a;
        cpu_wdata <= d;
        do begin
            @(negedge clk);
            n++;
        end while (cpu_done !== 1'h1 && n < 100);
        `CHECK("cpu_done", 1'h1, cpu_done)
        rd = cpu_rdata;
        @(posedge clk);
        cpu_req <= 1'h0;
    endtask : cpu

    // load pin pulse of one cycle is enough: synchronised on this clock
    task automatic fire(input int k);
        @(posedge clk);
        int_req <= (k == 0 || k == 4);
        xop_req <= (k == 1);
        vector_branch_instr <= (k == 3);
        load_restart_instr <= (k == 2 || k == 4);
        load_pin <= (k == 5);
        @(posedge clk);
        {int_req, xop_req, vector_branch_instr} <= 3'h0;
        {load_restart_instr, load_pin} <= 2'h0;
    endtask : fire

    task automatic wait_done(input string what);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (switch_done !== 1'h1 && n < 300);
        `CHECK(what, 1'h1, switch_done)
    endtask : wait_done

    task automatic do_switch(input int k, input logic [3:0] num,
            input logic [15:0] va, w, p, input logic xf);
        logic [15:0] st;
        st = w ^ 16'hC3A5;
        u_mem.poke(va, w);
        u_mem.poke(va + 16'h0002, p);
        @(posedge clk);
        {int_level, xop_num, vbranch_addr, cur_status} <= {num, num, va, st};
        fire(k);
        wait_done("switch_done");
        `CHECK("wp", w, wp)
        `CHECK("pc", p, pc)
        `CHECK("xop_flag", xf, xop_flag)
        `CHECK("r13", cur_wp, u_mem.peek(w + 16'h001A))
        `CHECK("r14", cur_pc, u_mem.peek(w + 16'h001C))
        `CHECK("r15", st, u_mem.peek(w + 16'h001E))
        cur_wp = w;
        cur_pc = p;
    endtask : do_switch

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_mem();
        u_mem.poke(16'h1002, 16'h5566);
        cpu(1'h1, 1'h0, 1'h0, 16'h1000, 16'h1234);
        `CHECK("word wr", 16'h1234, u_mem.peek(16'h1000))
        cpu(1'h0, 1'h1, 1'h0, 16'h1000, 16'h0000);
        `CHECK("even byte", 16'h0012, rd)
        cpu(1'h0, 1'h1, 1'h0, 16'h1001, 16'h0000);
        `CHECK("odd byte", 16'h0034, rd)
        cpu(1'h0, 1'h0, 1'h0, 16'h1001, 16'h0000);
        `CHECK("odd word rd", 16'h1234, rd)
        cpu(1'h1, 1'h0, 1'h0, 16'h1001, 16'hABCD);
        `CHECK("odd word wr", 16'hABCD, u_mem.peek(16'h1000))
        cpu(1'h0, 1'h1, 1'h1, 16'h1000, 16'h0000);
        `CHECK("signed byte", 16'hFFAB, rd)
        cpu(1'h1, 1'h1, 1'h0, 16'h1003, 16'h0077);
        `CHECK("odd byte wr", 16'h5577, u_mem.peek(16'h1002))
        cpu(1'h1, 1'h1, 1'h0, 16'h1002, 16'h0011);
        `CHECK("even byte wr", 16'h1177, u_mem.peek(16'h1002))
        cpu(1'h0, 1'h1, 1'h1, 16'h1003, 16'h0000);
        `CHECK("pos byte", 16'h0077, rd)
    endtask : t_mem

    task automatic t_fetch();
        for (int len = 0; len < 4; len++) begin
            @(posedge clk);
            fetch_adv <= 1'h1;
            instr_len <= 2'(len);
            @(posedge clk);
            fetch_adv <= 1'h0;
            @(negedge clk);
            cur_pc = cur_pc + 16'(2 * len);
            `CHECK("pc advance", cur_pc, pc)
        end
    endtask : t_fetch

    // interleaved so each interrupt also clears the extended flag
    task automatic t_vec();
        logic [15:0] n;
        for (int i = 0; i < 16; i++) begin
            n = 16'(i);
            do_switch(0, n[3:0], n << 2, 16'h0100 + (n << 5),
                16'h2000 + (n << 2), 1'h0);
            do_switch(1, n[3:0], 16'h0040 + (n << 2), 16'h0400 + (n << 5),
                16'h3000 + (n << 2), 1'h1);
        end
    endtask : t_vec

    task automatic t_misc();
        @(posedge clk);
        mem_wait <= 4'h3;
        do_switch(4, 4'h0, 16'hFFFC, 16'h0700, 16'h4000, 1'h0);
        do_switch(5, 4'h0, 16'hFFFC, 16'h0720, 16'h4100, 1'h0);
        do_switch(3, 4'h0, 16'h0300, 16'h0800, 16'h5000, 1'h0);
    endtask : t_misc

    task automatic t_hwx();
        @(posedge clk);
        hw_xop_present_pin <= 1'h1;
        repeat (4) @(posedge clk);
        mem_hits = 0;
        fire(1);
        repeat (4) @(negedge clk);
        `CHECK("hw busy", 1'h1, busy)
        @(posedge clk);
        hw_xop_done_pin <= 1'h1;
        wait_done("hw done");
        `CHECK("hw mem", 0, mem_hits)
        `CHECK("hw wp", cur_wp, wp)
        `CHECK("hw pc", cur_pc, pc)
        `CHECK("hw flag", 1'h0, xop_flag)
        @(posedge clk);
        {hw_xop_present_pin, hw_xop_done_pin} <= 2'h0;
        repeat (4) @(posedge clk);
    endtask : t_hwx

    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'h0;
        t_mem();
        t_fetch();
        t_vec();
        t_misc();
        t_hwx();
        results();
    end

    initial begin
        #1_000_000;
        miscompares++;
        results();
    end
endmodule : tb
